//--- cal_cfg.svh
// Purpose: shared constants of the calibration sequencer and its host.
// Assumes: 100 MHz clk_sys; timing is counted in conversion cycles.
// Notes: definitions only.
`ifndef CAL_CFG_SVH
`define CAL_CFG_SVH

// ************************************************************
// operation-mode field codes
// ************************************************************
`define CAL_MODE_NORMAL 3'h0
`define CAL_MODE_SELF 3'h1
`define CAL_MODE_SYS_OFS 3'h2
`define CAL_MODE_SYS_FS 3'h3
`define CAL_MODE_PSEUDO 3'h4
`define CAL_MODE_BACKGROUND 3'h5

// ************************************************************
// phase lengths in conversion periods
// ************************************************************
`define CAL_PHASE_LEN 3
`define CAL_PHASE_LEN_SLAVE 4
`define CAL_FILL_LEN 3
`define CAL_SETTLE_LEN 1
// background mode delivers one result per this many periods
`define CAL_BG_RATE_DIV 6

// ************************************************************
// timing: conversion period of the configured data rate
// ************************************************************
`define CLK_PERIOD_NS 10
`define CONV_PERIOD_NS 1000
`define CONV_PERIOD_CYC (`CONV_PERIOD_NS / `CLK_PERIOD_NS)

// reset values
`define CAL_REG_RESET 24'h000000

`endif

//--- cal_pkg.sv
// Purpose: types shared by both ends of the calibration link.
// Assumes: cal_cfg.svh holds the numeric constants.
// Notes: one-hot state codes are written out.
`include "cal_cfg.svh"
`default_nettype none

package cal_pkg;

	// sampling-capacitor source selection
	typedef enum logic [1:0] {
		CAP_INPUT = 2'h0,
		CAP_SHORT = 2'h1,
		CAP_REF = 2'h2
	} cap_sel_t;

	// device sequencer states
	typedef enum logic [4:0] {
		ST_NORM = 5'h01,
		ST_OFS = 5'h02,
		ST_GAIN = 5'h04,
		ST_FILL = 5'h08,
		ST_SETTLE = 5'h10
	} seq_state_t;

	// host command opcodes
	typedef enum logic [1:0] {
		OP_MODE = 2'h0,
		OP_OFS = 2'h1,
		OP_FS = 2'h2,
		OP_FULL_SYS = 2'h3
	} host_op_t;

	// host states
	typedef enum logic [3:0] {
		H_BOOT = 4'h1,
		H_IDLE = 4'h2,
		H_WAIT_OFS = 4'h4,
		H_FS_WR = 4'h8
	} host_state_t;

endpackage : cal_pkg

`default_nettype wire

//--- cal_link_if.sv
// Purpose: link between the host and the calibration sequencer.
// Assumes: both ends run on clk_sys.
// Notes: write strobes are one-cycle pulses from the host.
`default_nettype none

interface cal_link_if #(parameter int W = 24) ();
	// host to device
	logic mode_we;
	logic [2:0] mode_wdata;
	logic ofs_we;
	logic fs_we;
	logic [W-1:0] cal_wdata;
	// device to host
	logic [2:0] operation_mode_field;
	logic [W-1:0] ofs_val;
	logic [W-1:0] fs_val;
	logic result_valid_n;
	logic [W-1:0] result;

	modport device (
		input mode_we, mode_wdata, ofs_we, fs_we, cal_wdata,
		output operation_mode_field, ofs_val, fs_val, result_valid_n, result
	);
	modport host (
		output mode_we, mode_wdata, ofs_we, fs_we, cal_wdata,
		input operation_mode_field, ofs_val, fs_val, result_valid_n, result
	);
endinterface : cal_link_if

`default_nettype wire

//--- conv_timer.sv
// Purpose: marks the start of each conversion period.
// Assumes: period given in clk_sys cycles, at least two.
// Notes: tick is high for one cycle per period.
`include "cal_cfg.svh"
`default_nettype none

module conv_timer #(
	parameter int unsigned PERIOD_CYC = `CONV_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// period start
	output logic tick
);
	localparam logic [15:0] LAST = 16'(PERIOD_CYC - 1);

	logic [15:0] cnt_q;

	// free-running period counter
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q == LAST) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	assign tick = (cnt_q == LAST);

endmodule : conv_timer

`default_nettype wire

//--- cal_device.sv
// Purpose: calibration sequencer of a delta-sigma converter.
// Assumes: sample_in holds the filter output of the period just ended.
// Notes: offset correction is subtracted; gain value is passed to the datapath.
`include "cal_cfg.svh"
`default_nettype none

module cal_device
	import cal_pkg::*;
#(
	parameter int W = 24,
	parameter int unsigned PERIOD_CYC = `CONV_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// link to the host
	cal_link_if.device link,
	// converter configuration
	input wire logic slave_mode,
	// datapath side
	input wire logic [W-1:0] sample_in,
	output logic conv_start,
	output cap_sel_t cap_sel,
	output logic [W-1:0] corr_ofs,
	output logic [W-1:0] corr_fs
);

	// ************************************************************
	// decoding helpers
	// ************************************************************

	// codes that launch a sequence
	function automatic logic mode_is_cal(input logic [2:0] m);
		mode_is_cal = (m == `CAL_MODE_SELF) || (m == `CAL_MODE_SYS_OFS) ||
			(m == `CAL_MODE_SYS_FS) || (m == `CAL_MODE_PSEUDO) || (m == `CAL_MODE_BACKGROUND);
	endfunction : mode_is_cal

	localparam logic [2:0] LOAD_PHASE = 3'(`CAL_PHASE_LEN - 1);
	localparam logic [2:0] LOAD_SLAVE = 3'(`CAL_PHASE_LEN_SLAVE - 1);
	localparam logic [2:0] LOAD_FILL = 3'(`CAL_FILL_LEN - 1);
	localparam logic [2:0] LOAD_SETTLE = 3'(`CAL_SETTLE_LEN - 1);

	// ************************************************************
	// state
	// ************************************************************
	seq_state_t state_q, state_d;
	cap_sel_t cap_q, cap_d;
	logic [2:0] kind_q, kind_d;
	logic [2:0] mode_q, mode_d;
	logic [2:0] cnt_q, cnt_d;
	logic pend_q, pend_d;
	logic bg_gain_q, bg_gain_d;
	logic rvn_q, rvn_d;
	logic [W-1:0] ofs_q, ofs_d;
	logic [W-1:0] fs_q, fs_d;
	logic [W-1:0] result_q, result_d;
	logic clr_mode;
	logic cap_ofs;
	logic cap_fs;

	// ************************************************************
	// period timing
	// ************************************************************
	logic tick;

	conv_timer #(.PERIOD_CYC(PERIOD_CYC)) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick)
	);

	// first phase length of a new sequence
	wire logic [2:0] first_load = slave_mode ? LOAD_SLAVE : LOAD_PHASE;
	wire logic last = (cnt_q == 3'h0);

	// ************************************************************
	// mode field and pending start
	// ************************************************************

	// a host write made as the sequence ends still lands: write beats the clear
	always_comb begin
		if (link.mode_we) begin
			mode_d = link.mode_wdata;
		end else if (clr_mode) begin
			mode_d = `CAL_MODE_NORMAL;
		end else begin
			mode_d = mode_q;
		end
	end

	// a write takes effect at the next period boundary
	always_comb begin
		if (link.mode_we) begin
			pend_d = 1'b1;
		end else if (tick) begin
			pend_d = 1'b0;
		end else begin
			pend_d = pend_q;
		end
	end

	// ************************************************************
	// sequencer, advances only on period ticks
	// ************************************************************
	always_comb begin
		state_d = state_q;
		cap_d = cap_q;
		kind_d = kind_q;
		cnt_d = cnt_q;
		bg_gain_d = bg_gain_q;
		rvn_d = rvn_q;
		clr_mode = 1'b0;
		cap_ofs = 1'b0;
		cap_fs = 1'b0;
		if (tick) begin
			rvn_d = 1'b1;
			if (pend_q) begin
				kind_d = mode_q;
				cnt_d = first_load;
				bg_gain_d = 1'b0;
				case (mode_q)
					`CAL_MODE_SELF: begin
						state_d = ST_OFS;
						cap_d = CAP_SHORT;
					end
					`CAL_MODE_SYS_OFS: begin
						state_d = ST_OFS;
						cap_d = CAP_INPUT;
					end
					`CAL_MODE_SYS_FS: begin
						state_d = ST_GAIN;
						cap_d = CAP_INPUT;
					end
					`CAL_MODE_PSEUDO: begin
						state_d = ST_OFS;
						cap_d = CAP_INPUT;
					end
					`CAL_MODE_BACKGROUND: begin
						state_d = ST_OFS;
						cap_d = CAP_SHORT;
					end
					default: begin
						// normal or unsupported code: plain conversions
						state_d = ST_NORM;
						cap_d = CAP_INPUT;
					end
				endcase
			end else begin
				case (state_q)
					ST_NORM: begin
						rvn_d = mode_is_cal(mode_q);
					end
					ST_OFS: begin
						if (!last) begin
							cnt_d = cnt_q - 3'h1;
						end else begin
							cap_ofs = 1'b1;
							case (kind_q)
								`CAL_MODE_SYS_OFS: begin
									clr_mode = 1'b1;
									state_d = ST_SETTLE;
									cnt_d = LOAD_SETTLE;
								end
								`CAL_MODE_BACKGROUND: begin
									state_d = ST_FILL;
									cap_d = CAP_INPUT;
									cnt_d = LOAD_FILL;
									bg_gain_d = 1'b1;
								end
								default: begin
									state_d = ST_GAIN;
									cap_d = CAP_REF;
									cnt_d = LOAD_PHASE;
								end
							endcase
						end
					end
					ST_GAIN: begin
						if (!last) begin
							cnt_d = cnt_q - 3'h1;
						end else begin
							cap_fs = 1'b1;
							cap_d = CAP_INPUT;
							case (kind_q)
								`CAL_MODE_SYS_FS: begin
									clr_mode = 1'b1;
									state_d = ST_SETTLE;
									cnt_d = LOAD_SETTLE;
								end
								`CAL_MODE_BACKGROUND: begin
									state_d = ST_FILL;
									cnt_d = LOAD_FILL;
								end
								default: begin
									clr_mode = 1'b1;
									state_d = ST_FILL;
									cnt_d = LOAD_FILL;
								end
							endcase
						end
					end
					ST_FILL: begin
						if (!last) begin
							cnt_d = cnt_q - 3'h1;
						end else if (kind_q == `CAL_MODE_BACKGROUND) begin
							// valid period overlaps the next calibration phase
							rvn_d = 1'b0;
							cnt_d = LOAD_PHASE;
							if (bg_gain_q) begin
								state_d = ST_GAIN;
								cap_d = CAP_REF;
								bg_gain_d = 1'b0;
							end else begin
								state_d = ST_OFS;
								cap_d = CAP_SHORT;
							end
						end else begin
							state_d = ST_NORM;
							rvn_d = 1'b0;
						end
					end
					ST_SETTLE: begin
						if (!last) begin
							cnt_d = cnt_q - 3'h1;
						end else begin
							state_d = ST_NORM;
							rvn_d = 1'b0;
						end
					end
					default: begin
						state_d = ST_NORM;
						cap_d = CAP_INPUT;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// calibration registers and corrected result
	// ************************************************************

	// the sequencer's own capture beats a host write in the same cycle
	assign ofs_d = cap_ofs ? sample_in : (link.ofs_we ? link.cal_wdata : ofs_q);
	assign fs_d = cap_fs ? sample_in : (link.fs_we ? link.cal_wdata : fs_q);
	// offset applied to every conversion; gain goes out on corr_fs
	assign result_d = tick ? W'(sample_in - ofs_q) : result_q;

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_NORM;
			cap_q <= CAP_INPUT;
			kind_q <= `CAL_MODE_NORMAL;
			mode_q <= `CAL_MODE_NORMAL;
			cnt_q <= 3'h0;
			pend_q <= 1'b0;
			bg_gain_q <= 1'b0;
			rvn_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cap_q <= cap_d;
			kind_q <= kind_d;
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
			bg_gain_q <= bg_gain_d;
			rvn_q <= rvn_d;
		end
	end

	// datapath words
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ofs_q <= W'(`CAL_REG_RESET);
			fs_q <= W'(`CAL_REG_RESET);
			result_q <= W'(`CAL_REG_RESET);
		end else begin
			ofs_q <= ofs_d;
			fs_q <= fs_d;
			result_q <= result_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign link.operation_mode_field = mode_q;
	assign link.ofs_val = ofs_q;
	assign link.fs_val = fs_q;
	assign link.result_valid_n = rvn_q;
	assign link.result = result_q;
	assign conv_start = tick;
	assign cap_sel = cap_q;
	assign corr_ofs = ofs_q;
	assign corr_fs = fs_q;

endmodule : cal_device

`default_nettype wire

//--- cal_host.sv
// Purpose: host-side controller of the calibration link.
// Assumes: same clk_sys as the device; link signals need no sync.
// Notes: issues self-calibration after reset and on config change.
`include "cal_cfg.svh"
`default_nettype none

module cal_host
	import cal_pkg::*;
#(
	parameter int W = 24
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// link to the device
	cal_link_if.host link,
	// command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire host_op_t cmd_op,
	input wire logic [W-1:0] cmd_data,
	input wire logic cfg_changed,
	// readback
	output logic [2:0] mode_now,
	output logic [W-1:0] ofs_now,
	output logic [W-1:0] fs_now,
	output logic [W-1:0] data_now,
	output logic data_valid_n
);

	host_state_t state_q, state_d;
	logic recal_q, recal_d;
	logic seen_q, seen_d;
	logic mode_we_q, mode_we_d;
	logic ofs_we_q, ofs_we_d;
	logic fs_we_q, fs_we_d;
	logic [2:0] mode_wdata_q, mode_wdata_d;
	logic [W-1:0] wdata_q, wdata_d;

	wire logic idle = (state_q == H_IDLE);
	wire logic take = idle && !recal_q && cmd_valid;
	// offset pass counts as done once the mode is back and data is valid
	wire logic ofs_done = seen_q && (link.operation_mode_field == `CAL_MODE_NORMAL) && !link.result_valid_n;

	assign cmd_ready = idle && !recal_q;

	// ************************************************************
	// command sequencing
	// ************************************************************
	always_comb begin
		state_d = state_q;
		recal_d = recal_q | cfg_changed;
		seen_d = seen_q;
		mode_we_d = 1'b0;
		ofs_we_d = 1'b0;
		fs_we_d = 1'b0;
		mode_wdata_d = mode_wdata_q;
		wdata_d = wdata_q;
		case (state_q)
			H_BOOT: begin
				mode_we_d = 1'b1;
				mode_wdata_d = `CAL_MODE_SELF;
				state_d = H_IDLE;
			end
			H_IDLE: begin
				if (recal_q) begin
					recal_d = cfg_changed;
					mode_we_d = 1'b1;
					mode_wdata_d = `CAL_MODE_SELF;
				end else if (cmd_valid) begin
					case (cmd_op)
						OP_MODE: begin
							mode_we_d = 1'b1;
							mode_wdata_d = cmd_data[2:0];
						end
						OP_OFS: begin
							ofs_we_d = 1'b1;
							wdata_d = cmd_data;
						end
						OP_FS: begin
							fs_we_d = 1'b1;
							wdata_d = cmd_data;
						end
						default: begin
							mode_we_d = 1'b1;
							mode_wdata_d = `CAL_MODE_SYS_OFS;
							seen_d = 1'b0;
							state_d = H_WAIT_OFS;
						end
					endcase
				end
			end
			H_WAIT_OFS: begin
				if (link.operation_mode_field == `CAL_MODE_SYS_OFS) begin
					seen_d = 1'b1;
				end
				if (ofs_done) begin
					state_d = H_FS_WR;
				end
			end
			H_FS_WR: begin
				mode_we_d = 1'b1;
				mode_wdata_d = `CAL_MODE_SYS_FS;
				state_d = H_IDLE;
			end
			default: begin
				state_d = H_IDLE;
			end
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= H_BOOT;
			recal_q <= 1'b0;
			seen_q <= 1'b0;
			mode_we_q <= 1'b0;
			ofs_we_q <= 1'b0;
			fs_we_q <= 1'b0;
			mode_wdata_q <= `CAL_MODE_NORMAL;
			wdata_q <= W'(`CAL_REG_RESET);
		end else begin
			state_q <= state_d;
			recal_q <= recal_d;
			seen_q <= seen_d;
			mode_we_q <= mode_we_d;
			ofs_we_q <= ofs_we_d;
			fs_we_q <= fs_we_d;
			mode_wdata_q <= mode_wdata_d;
			wdata_q <= wdata_d;
		end
	end

	// readback copies
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_now <= `CAL_MODE_NORMAL;
			ofs_now <= W'(`CAL_REG_RESET);
			fs_now <= W'(`CAL_REG_RESET);
			data_now <= W'(`CAL_REG_RESET);
			data_valid_n <= 1'b1;
		end else begin
			mode_now <= link.operation_mode_field;
			ofs_now <= link.ofs_val;
			fs_now <= link.fs_val;
			data_now <= link.result;
			data_valid_n <= link.result_valid_n;
		end
	end

	// link drive
	assign link.mode_we = mode_we_q;
	assign link.mode_wdata = mode_wdata_q;
	assign link.ofs_we = ofs_we_q;
	assign link.fs_we = fs_we_q;
	assign link.cal_wdata = wdata_q;

	// unused: take kept for readability of the ready term
	wire logic unused_take = take;

endmodule : cal_host

`default_nettype wire

//--- cal_link_sva.sv
// Purpose: timing checks on the calibration link.
// Assumes: P is the conversion period in clk_sys cycles.
// Notes: windows are counted from the last mode write.
`default_nettype none

module cal_link_sva #(
	parameter int unsigned P = 100,
	parameter int W = 24
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// host to device
	input wire logic mode_we,
	input wire logic [2:0] mode_wdata,
	input wire logic ofs_we,
	input wire logic fs_we,
	input wire logic [W-1:0] cal_wdata,
	// device to host
	input wire logic [2:0] operation_mode_field,
	input wire logic [W-1:0] ofs_val,
	input wire logic [W-1:0] fs_val,
	input wire logic result_valid_n,
	input wire logic [W-1:0] result
);
	// ****
	// helper counters
	// ****
	logic [15:0] since_q;
	logic [15:0] gap_q;
	logic [2:0] code_q;
	logic rvn_q;
	logic seen_q;
	// decoded conditions
	wire logic fell_w = rvn_q & ~result_valid_n;
	wire logic long_w = (code_q == 3'h1) || (code_q == 3'h4);
	wire logic sys_w = (code_q == 3'h2) || (code_q == 3'h3);
	wire logic quiet_w = (operation_mode_field == 3'h0) && !result_valid_n;

	// saturating, so a long run never wraps back into a window
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			since_q <= 16'h0000;
			gap_q <= 16'h0000;
			code_q <= 3'h0;
			rvn_q <= 1'b1;
			seen_q <= 1'b0;
		end else begin
			since_q <= mode_we ? 16'h0001 : since_q + {15'h0000, ~&since_q};
			gap_q <= fell_w ? 16'h0001 : gap_q + {15'h0000, ~&gap_q};
			code_q <= mode_we ? mode_wdata : code_q;
			rvn_q <= result_valid_n;
			seen_q <= !mode_we && (seen_q || (fell_w && operation_mode_field == 3'h5));
		end
	end

	// ****
	// assertions
	// ****
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_mode_take: assert property (mode_we |=> operation_mode_field == $past(mode_wdata))
		else $error("mode field missed a write");
	a_mode_clear: assert property (!mode_we && operation_mode_field != 3'h0
		|=> operation_mode_field == 3'h0 || $stable(operation_mode_field))
		else $error("mode field changed to a code nobody wrote");
	a_bg_stays: assert property (!mode_we && operation_mode_field == 3'h5 |=> operation_mode_field == 3'h5)
		else $error("background mode left by itself");
	a_cal_busy: assert property ((long_w && since_q >= P + 2 && since_q <= 9 * P)
		|| (sys_w && since_q >= P + 2 && since_q <= 3 * P) |-> result_valid_n)
		else $error("data ready during calibration");
	a_bg_busy: assert property (code_q == 3'h5 && since_q >= P + 2 && since_q <= 5 * P |-> result_valid_n)
		else $error("data ready during first background phases");
	a_self_done: assert property (long_w && since_q == 11 * P + 2 |-> !result_valid_n)
		else $error("no valid data after self or pseudo calibration");
	a_sys_done: assert property (sys_w && since_q == 6 * P + 2 |-> !result_valid_n)
		else $error("no valid data after system calibration");
	a_bg_rate: assert property (seen_q && fell_w && operation_mode_field == 3'h5 |-> gap_q == 6 * P)
		else $error("background result spacing wrong");
	a_ofs_write: assert property (ofs_we && !mode_we && quiet_w |=> ofs_val == $past(cal_wdata))
		else $error("offset register write lost");
	a_fs_write: assert property (fs_we && !mode_we && quiet_w |=> fs_val == $past(cal_wdata))
		else $error("full-scale register write lost");
	a_regs_hold: assert property (!ofs_we && !fs_we && !mode_we && quiet_w
		|=> $stable(ofs_val) && $stable(fs_val))
		else $error("calibration registers drifted");
endmodule : cal_link_sva

`default_nettype wire

//--- adc_calibration_sequencer_tb.sv
// Purpose: self-checking bench for the host and sequencer pair.
// Assumes: conversion period shortened to four cycles.
// Notes: expected registers come from a tick-indexed sample model.
`default_nettype none

module adc_calibration_sequencer_tb
	import cal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned P = 4;
	logic clk_sys, rst, slave_mode, cmd_valid, cfg_changed, conv_start, cmd_ready, data_valid_n;
	logic [23:0] sample_in, cmd_data, ofs_exp, fs_exp, res_exp, corr_ofs, corr_fs, ofs_now, fs_now, data_now;
	logic [2:0] mode_now;
	logic [31:0] lfsr;
	host_op_t cmd_op;
	cap_sel_t cap_sel;
	int n_errors, n_compared, tick_n, t0, o_t, f_t, b, tb;

	// ****
	// the two ends and the checker
	// ****
	cal_link_if #(.W(24)) link ();
	cal_device #(.W(24), .PERIOD_CYC(P)) cal_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
		.slave_mode(slave_mode), .sample_in(sample_in), .conv_start(conv_start), .cap_sel(cap_sel),
		.corr_ofs(corr_ofs), .corr_fs(corr_fs));
	cal_host #(.W(24)) cal_host_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cfg_changed(cfg_changed),
		.mode_now(mode_now), .ofs_now(ofs_now), .fs_now(fs_now), .data_now(data_now),
		.data_valid_n(data_valid_n));
	cal_link_sva #(.P(P), .W(24)) cal_link_sva_inst (.clk_sys(clk_sys), .rst(rst), .mode_we(link.mode_we),
		.mode_wdata(link.mode_wdata), .ofs_we(link.ofs_we), .fs_we(link.fs_we), .cal_wdata(link.cal_wdata),
		.operation_mode_field(link.operation_mode_field), .ofs_val(link.ofs_val), .fs_val(link.fs_val),
		.result_valid_n(link.result_valid_n), .result(link.result));

	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : next_rand

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// random filter output every cycle
	always @(posedge clk_sys) begin
		lfsr <= next_rand(lfsr);
		sample_in <= lfsr[23:0];
	end

	// tick-indexed model; background captures are left out, so its registers are rewritten after it
	always @(posedge clk_sys) begin
		b = tick_n + int'(conv_start) + 3 + int'(slave_mode);
		if (link.mode_we) begin
			t0 <= b - 3 - int'(slave_mode);
			o_t <= (link.mode_wdata inside {3'h1, 3'h2, 3'h4}) ? b : -1;
			f_t <= (link.mode_wdata == 3'h3) ? b : (link.mode_wdata inside {3'h1, 3'h4}) ? b + 3 : -1;
		end
		if (link.ofs_we)
			ofs_exp <= link.cal_wdata;
		if (link.fs_we)
			fs_exp <= link.cal_wdata;
		if (conv_start) begin
			tick_n <= tick_n + 1;
			res_exp <= sample_in - ofs_exp;
			if (tick_n == o_t)
				ofs_exp <= sample_in;
			if (tick_n == f_t)
				fs_exp <= sample_in;
		end
	end

	// ****
	// shared tasks
	// ****
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// request held until the edge where ready is seen
	task automatic cmd(input host_op_t op, input logic [23:0] d);
		int k;
		cmd_op <= op;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (cmd_ready !== 1'b1 && k < 3000);
		cmd_valid <= 1'b0;
		if (k >= 3000)
			check("cmd_ready", 24'h000000, 24'h000001);
	endtask : cmd

	task automatic wait_rvn(input logic lvl);
		int k;
		k = 0;
		while (link.result_valid_n !== lvl && k < 3000) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 3000)
			check("result_valid_n", {23'h000000, !lvl}, {23'h000000, lvl});
	endtask : wait_rvn

	// one calibration, timed in conversion ticks from its start
	task automatic run_cal(input logic go, input logic [2:0] code);
		int lat;
		lat = ((code inside {3'h2, 3'h3}) ? 5 : 10) + int'(slave_mode);
		if (go)
			cmd(OP_MODE, {21'h000000, code});
		wait_rvn(1'b1);
		// capacitor source just after the start tick, then just after the first phase ends
		if (go) begin
			check("cap_first", {22'h000000, cap_sel}, (code == 3'h1) ? 24'h000001 : 24'h000000);
			repeat ((3 + int'(slave_mode)) * P) @(posedge clk_sys);
			check("cap_second", {22'h000000, cap_sel}, (code inside {3'h1, 3'h4}) ? 24'h000002 : 24'h000000);
		end
		wait_rvn(1'b0);
		check("latency", 24'(tick_n - t0), 24'(lat));
		repeat (2) @(posedge clk_sys);
		check("mode", {21'h000000, mode_now}, 24'h000000);
		check("data_now", data_now, res_exp);
		check("ofs", ofs_now, ofs_exp);
		check("fs", fs_now, fs_exp);
	endtask : run_cal

	// ****
	// main sequence
	// ****
	initial begin
		rst = 1'b1;
		lfsr = 32'h00003671;
		sample_in = 24'h000000;
		slave_mode = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_MODE;
		cmd_data = 24'h000000;
		cfg_changed = 1'b0;
		{ofs_exp, fs_exp, res_exp} = '0;
		{n_errors, n_compared, tick_n, t0, tb} = '0;
		o_t = -1;
		f_t = -1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		run_cal(1'b0, 3'h1);
		// every one-shot mode back to back, slave chosen at random
		for (int i = 0; i < 8; i++) begin
			slave_mode <= lfsr[0];
			@(posedge clk_sys);
			run_cal(1'b1, 3'(i % 4 + 1));
		end
		cmd(OP_FULL_SYS, 24'h000000);
		wait_rvn(1'b1);
		wait_rvn(1'b0);
		wait_rvn(1'b1);
		check("order", {21'h000000, mode_now}, 24'h000003);
		run_cal(1'b0, 3'h3);
		cmd(OP_MODE, 24'h000005);
		wait_rvn(1'b1);
		wait_rvn(1'b0);
		tb = tick_n;
		wait_rvn(1'b1);
		wait_rvn(1'b0);
		check("bg_rate", 24'(tick_n - tb), 24'h000006);
		check("bg_mode", {21'h000000, mode_now}, 24'h000005);
		cmd(OP_MODE, 24'h000007);
		repeat (3 * P) @(posedge clk_sys);
		check("leave", {23'h000000, data_valid_n}, 24'h000000);
		cmd(OP_MODE, 24'h000000);
		cmd(OP_OFS, lfsr[23:0]);
		cmd(OP_FS, lfsr[31:8]);
		repeat (3 * P) @(posedge clk_sys);
		check("ofs_wr", ofs_now, ofs_exp);
		check("fs_wr", fs_now, fs_exp);
		check("corr_ofs", corr_ofs, ofs_exp);
		check("corr_fs", corr_fs, fs_exp);
		check("result", link.result, res_exp);
		cfg_changed <= 1'b1;
		@(posedge clk_sys);
		cfg_changed <= 1'b0;
		run_cal(1'b0, 3'h1);
		test_done();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		test_done();
	end
endmodule : adc_calibration_sequencer_tb

`default_nettype wire
